/* File: dv/link_master_model.sv */
/*
 Outside master model: makes the link clock and drives the strobes.
 Assumes the bench calls its tasks at a falling edge, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module link_master_model (
    // Core clock for pacing
    input wire logic clk_in,
    // Pins toward the port
    output logic lclk_out,
    output logic cs_out,
    output logic oe_out,
    output logic rd_out,
    output logic wr_out,
    output logic pkt_out,
    output logic [1:0] sel_out,
    output logic [15:0] data_out
);
    // Idle pins
    initial begin
        {lclk_out, cs_out, oe_out, rd_out, wr_out, pkt_out} = 6'h00;
        sel_out = 2'h0;
        data_out = 16'h0000;
    end

    // One link clock: pins set while low, held over the rise
    task automatic xfer(input logic c, r, w, p, input logic [1:0] s,
            input logic [15:0] d);
        lclk_out = 1'b0;
        cs_out = c;
        sel_out = s;
        rd_out = r;
        wr_out = w;
        pkt_out = p;
        data_out = w ? d : ~data_out; // Stale bus is not kept
        repeat (4) @(negedge clk_in);
        lclk_out = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask : xfer

    // Output enable alone
    task automatic set_oe(input logic v);
        oe_out = v;
    endtask : set_oe
endmodule : link_master_model
`default_nettype wire

/* File: dv/slave_fifo_host_port_tb.sv */
/*
 Bench for the slave FIFO host port, with queue reference model.
 Assumes the master model file and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module slave_fifo_host_port_tb;
    import slave_port_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic lclk, cs, oe, rd, wr, pkt, doe, emp, ful, pdone;
    logic ace = 1'b0;
    logic [1:0] sel, psel;
    logic [4:0] acl = 5'h00;
    logic [4:0] pwords;
    word_type din, dout;
    word_type q[4][$];
    int opn[4];
    int exp_pk[$];
    int got_pk[$];
    int mismatches = 0;
    int compares = 0;
    logic cl_valid = 1'b0;
    logic cl_rdy;
    logic [1:0] cl_sel = 2'h0;
    word_type cl_data = 16'h0000;

    // Clock
    initial begin
        forever #50 core_clk_in = ~core_clk_in;
    end

    link_master_model link_master_model_i (.clk_in(core_clk_in),
        .lclk_out(lclk), .cs_out(cs), .oe_out(oe), .rd_out(rd),
        .wr_out(wr), .pkt_out(pkt), .sel_out(sel), .data_out(din));

    slave_fifo_host_port slave_fifo_host_port_i (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .interface_clock_in(lclk),
        .fifo_chip_select_in(cs), .fifo_output_enable_in(oe),
        .fifo_read_strobe_in(rd), .fifo_write_strobe_in(wr),
        .packet_commit_strobe_in(pkt), .fifo_select_lines_in(sel),
        .fifo_data_in(din), .fifo_data_out(dout), .fifo_data_oe_out(doe),
        .fifo_empty_out(emp), .fifo_full_out(ful),
        .core_load_valid_in(cl_valid), .core_load_select_in(cl_sel),
        .core_load_data_in(cl_data), .core_load_ready_out(cl_rdy),
        .auto_commit_enable_in(ace), .auto_commit_length_in(acl),
        .packet_done_out(pdone), .packet_select_out(psel),
        .packet_words_out(pwords));

    // Collect packet reports mid-cycle, clear of the launch edge
    always @(negedge core_clk_in) begin
        if (pdone === 1'b1)
            got_pk.push_back(int'(psel) * 32 + int'(pwords));
    end

    task automatic chk(input logic [15:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    // Drive one link cycle, update the model, compare
    task automatic op(input logic c, r, w, p, input logic [1:0] s,
            input word_type d);
        logic wrote;
        link_master_model_i.xfer(c, r, w, p, s, d);
        wrote = c && w && q[s].size() < 16;
        if (wrote)
            q[s].push_back(d);
        opn[s] += int'(wrote);
        if (c && p) begin
            exp_pk.push_back(s * 32 + opn[s]);
            opn[s] = 0;
        end else if (wrote && ace && acl != 0 && opn[s] == acl) begin
            exp_pk.push_back(s * 32 + acl);
            opn[s] = 0;
        end
        if (c && r && q[s].size() > 0)
            void'(q[s].pop_front());
        chk(16'(emp), 16'(q[s].size() == 0), "empty");
        chk(16'(cl_rdy), 16'(q[cl_sel].size() < 16), "ready");
        chk(16'(ful), 16'(q[s].size() == 16), "full");
        chk(16'(doe), 16'(oe), "drive");
        if (oe && q[s].size() > 0)
            chk(dout, q[s][0], "data");
        chk(16'(got_pk.size()), 16'(exp_pk.size()), "pkts");
        while (got_pk.size() > 0 && exp_pk.size() > 0)
            chk(16'(got_pk.pop_front()), 16'(exp_pk.pop_front()), "pkt");
        got_pk.delete();
        exp_pk.delete();
    endtask : op

    // Core side push, held until the port takes it
    task automatic load(input logic [1:0] s, input word_type d);
        cl_valid = 1'b1;
        cl_sel = s;
        cl_data = d;
        @(posedge core_clk_in);
        while (cl_rdy !== 1'b1)
            @(posedge core_clk_in);
        @(negedge core_clk_in);
        cl_valid = 1'b0;
        q[s].push_back(d);
    endtask : load

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // Watchdog
    initial begin
        #500us;
        mismatches++;
        conclude();
    end

    // Scenarios
    initial begin
        void'($urandom(32'h1330_1b34));
        repeat (20) @(negedge core_clk_in);
        reset_in = 1'b0;
        for (int f = 0; f < 4; f++) begin
            for (int i = 0; i < 3; i++)
                op(1, 0, 1, f < 2 && i == 2, 2'(f), 16'($urandom));
        end
        op(1, 0, 0, 1, 2, 0);
        op(1, 0, 0, 1, 3, 0);
        op(0, 0, 1, 1, 0, 16'h1234);
        op(0, 1, 0, 0, 1, 0);
        cl_sel = 2'h1;
        repeat (14) op(1, 0, 1, 0, 1, 16'($urandom));
        link_master_model_i.set_oe(1);
        op(1, 0, 0, 0, 1, 0);
        repeat (17) op(1, 1, 0, 0, 1, 0);
        link_master_model_i.set_oe(0);
        op(1, 1, 0, 0, 2, 0);
        link_master_model_i.set_oe(1);
        op(1, 0, 0, 0, 2, 0);
        load(2'h1, 16'($urandom));
        op(1, 0, 0, 0, 1, 0);
        op(1, 1, 0, 0, 1, 0);
        ace = 1'b1;
        acl = 5'h03;
        repeat (3) op(1, 0, 1, 0, 0, 16'($urandom));
        op(1, 0, 1, 1, 0, 16'($urandom));
        conclude();
    end
endmodule : slave_fifo_host_port_tb
`default_nettype wire

/* File: logic/slave_fifo_host_port.sv */
/*
 Slave FIFO host port: four FIFOs that an outside master writes and reads
 over a parallel bus, timed by its own interface clock.
 Assumes every pin arrives asynchronously and that the interface clock is
 much slower than core_clk_in, so each of its rising edges is seen once.
 Core side loads share the write port and wait out the cycle in which a
 link edge is handled, so the two never collide on one FIFO.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slave_port_map.svh"

module slave_fifo_host_port
    import slave_port_pkg::*;
#(
    parameter int DATA_W = `SPM_DATA_W,
    parameter int DEPTH_LOG2 = `SPM_DEPTH_LOG2
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Master pins
    input wire logic interface_clock_in,
    input wire logic fifo_chip_select_in,
    input wire logic fifo_output_enable_in,
    input wire logic fifo_read_strobe_in,
    input wire logic fifo_write_strobe_in,
    input wire logic packet_commit_strobe_in,
    input wire logic [1:0] fifo_select_lines_in,
    input wire logic [DATA_W-1:0] fifo_data_in,
    output logic [DATA_W-1:0] fifo_data_out,
    output logic fifo_data_oe_out,
    output logic fifo_empty_out,
    output logic fifo_full_out,
    // Core side fill port
    input wire logic core_load_valid_in,
    input wire logic [1:0] core_load_select_in,
    input wire logic [DATA_W-1:0] core_load_data_in,
    output logic core_load_ready_out,
    // Packet commit report
    input wire logic auto_commit_enable_in,
    input wire logic [DEPTH_LOG2:0] auto_commit_length_in,
    output logic packet_done_out,
    output logic [1:0] packet_select_out,
    output logic [DEPTH_LOG2:0] packet_words_out
);
    localparam int DEPTH = 1 << DEPTH_LOG2;
    localparam int NF = `SPM_FIFO_CNT;
    localparam int SW = 8 + DATA_W; // Clock, five strobes, select, data

    typedef logic [DEPTH_LOG2-1:0] ptr_type;
    typedef logic [DEPTH_LOG2:0] cnt_type;

    // Pointer step with wrap
    function automatic ptr_type bump(input ptr_type p, input logic en);
        bump = en ? ptr_type'(p + 1'b1) : p;
    endfunction : bump

    // Two-stage pin synchronisers
    logic [SW-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
    logic clk_prev_reg, clk_prev_next;
    always_comb begin
        sync1_next = {interface_clock_in, fifo_chip_select_in,
            fifo_output_enable_in, fifo_read_strobe_in,
            fifo_write_strobe_in, packet_commit_strobe_in,
            fifo_select_lines_in, fifo_data_in};
        sync2_next = sync1_reg;
        clk_prev_next = sync2_reg[SW-1]; // Edge finder reads stage two only
    end

    // Synchroniser registers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            clk_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            clk_prev_reg <= clk_prev_next;
        end
    end

    logic clk_s, cs_s, oe_s, rd_s, wr_s, pkt_s;
    logic [1:0] sel_s;
    logic [DATA_W-1:0] din_s;
    logic link_edge;
    assign {clk_s, cs_s, oe_s, rd_s, wr_s, pkt_s, sel_s, din_s} = sync2_reg;
    assign link_edge = clk_s & ~clk_prev_reg;

    // FIFO state
    logic [DATA_W-1:0] mem [NF][DEPTH];
    ptr_type wr_ptr_reg [NF], wr_ptr_next [NF];
    ptr_type rd_ptr_reg [NF], rd_ptr_next [NF];
    cnt_type count_reg [NF], count_next [NF];
    cnt_type pend_reg [NF], pend_next [NF];
    logic [DATA_W-1:0] data_reg, data_next;
    logic empty_reg, empty_next, full_reg, full_next;
    logic done_reg, done_next;
    logic [1:0] psel_reg, psel_next;
    cnt_type pwords_reg, pwords_next;

    logic rd_ev, wr_ev, pkt_ev, load_ev, auto_ev;
    logic push [NF];
    logic pop [NF];
    logic mem_we;
    logic [1:0] mem_sel;
    logic [DATA_W-1:0] mem_din;

    // Strobe decode for the selected FIFO
    always_comb begin
        rd_ev = link_edge & cs_s & rd_s
            & (count_reg[sel_s] != '0);
        wr_ev = link_edge & cs_s & wr_s
            & (count_reg[sel_s] != cnt_type'(DEPTH));
        pkt_ev = link_edge & cs_s & pkt_s;
        core_load_ready_out = ~link_edge
            & (count_reg[core_load_select_in] != cnt_type'(DEPTH));
        load_ev = core_load_valid_in & core_load_ready_out;
        mem_we = wr_ev | load_ev;
        mem_sel = wr_ev ? sel_s : core_load_select_in;
        mem_din = wr_ev ? din_s : core_load_data_in;
    end

    // Pointer, fill and commit bookkeeping per FIFO
    always_comb begin
        auto_ev = 1'b0;
        done_next = 1'b0;
        psel_next = psel_reg;
        pwords_next = pwords_reg;
        for (int i = 0; i < NF; i++) begin
            push[i] = mem_we & (mem_sel == 2'(i));
            pop[i] = rd_ev & (sel_s == 2'(i));
            wr_ptr_next[i] = bump(wr_ptr_reg[i], push[i]);
            rd_ptr_next[i] = bump(rd_ptr_reg[i], pop[i]);
            count_next[i] = cnt_type'(count_reg[i] + cnt_type'(push[i])
                - cnt_type'(pop[i]));
            // Words of the open packet, same-edge word included
            pend_next[i] = cnt_type'(pend_reg[i]
                + cnt_type'(wr_ev & (sel_s == 2'(i))));
        end
        if (pkt_ev) begin
            done_next = 1'b1;
            psel_next = sel_s;
            pwords_next = pend_next[sel_s];
            pend_next[sel_s] = '0;
        end else if (auto_commit_enable_in && wr_ev
            && auto_commit_length_in != '0
            && pend_next[sel_s] == auto_commit_length_in) begin
            auto_ev = 1'b1;
            done_next = 1'b1;
            psel_next = sel_s;
            pwords_next = pend_next[sel_s];
            pend_next[sel_s] = '0;
        end
        // Flags of the selected FIFO after this edge
        empty_next = (count_next[sel_s] == '0);
        full_next = (count_next[sel_s] == cnt_type'(DEPTH));
        // Prefetch the word at the read pointer
        data_next = mem[sel_s][rd_ptr_next[sel_s]];
    end

    // Registers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < NF; i++) begin
                wr_ptr_reg[i] <= `SPM_PTR_RST;
                rd_ptr_reg[i] <= `SPM_PTR_RST;
                count_reg[i] <= '0;
                pend_reg[i] <= '0;
            end
            data_reg <= `SPM_DATA_RST;
            empty_reg <= 1'b1;
            full_reg <= 1'b0;
            done_reg <= 1'b0;
            psel_reg <= '0;
            pwords_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            pend_reg <= pend_next;
            data_reg <= data_next;
            empty_reg <= empty_next;
            full_reg <= full_next;
            done_reg <= done_next;
            psel_reg <= psel_next;
            pwords_reg <= pwords_next;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge core_clk_in) begin
        if (mem_we) begin
            mem[mem_sel][wr_ptr_reg[mem_sel]] <= mem_din;
        end
    end

    // Outputs
    assign fifo_data_out = data_reg;
    assign fifo_data_oe_out = oe_s;
    assign fifo_empty_out = empty_reg;
    assign fifo_full_out = full_reg;
    assign packet_done_out = done_reg;
    assign packet_select_out = psel_reg;
    assign packet_words_out = pwords_reg;

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    AST_OE_ONLY_DRIVES: assert property (
        (oe_s && !(link_edge && cs_s && rd_s))
        |=> rd_ptr_reg[$past(sel_s)] == $past(rd_ptr_reg[sel_s]))
        else $error("output enable moved a read pointer");
    AST_OE_GATES_BUS: assert property (
        (!$past(reset_in) && !$past(reset_in, 2))
        |-> fifo_data_oe_out == $past(fifo_output_enable_in, 2))
        else $error("bus drive does not follow output enable");
    AST_PREFETCH_WORD: assert property (
        (!rd_ev && !mem_we && $stable(sel_s) && !reset_in)
        |=> fifo_data_out == mem[$past(sel_s)][rd_ptr_reg[$past(sel_s)]])
        else $error("bus word is not the word at the read pointer");
    AST_READ_ADVANCES: assert property (
        rd_ev |=> rd_ptr_reg[$past(sel_s)]
            == ptr_type'($past(rd_ptr_reg[sel_s]) + 1'b1))
        else $error("read edge did not advance the pointer");
    AST_READ_NEEDS_CS: assert property (
        rd_ev |-> $past(fifo_chip_select_in, 2)
            && $past(fifo_read_strobe_in, 2))
        else $error("read taken without chip select and strobe");
    AST_WRITE_STORES: assert property (
        wr_ev |=> mem[$past(sel_s)][$past(wr_ptr_reg[sel_s])]
            == $past(din_s))
        else $error("written word not stored");
    AST_WRITE_NEEDS_CS: assert property (
        (link_edge && wr_s && !cs_s)
        |=> count_reg[$past(sel_s)] == $past(count_reg[sel_s]))
        else $error("write taken without chip select");
    AST_FLAGS_FOLLOW: assert property (
        wr_ev |=> ##1 fifo_empty_out == 1'b0)
        else $error("empty flag did not clear after a write");
    AST_COMMIT_SAME_EDGE: assert property (
        (pkt_ev && wr_ev) |=> packet_done_out
            && packet_words_out == cnt_type'($past(pend_reg[sel_s]) + 1'b1))
        else $error("same-edge word missing from packet");
    AST_COMMIT_REPORT: assert property (
        pkt_ev |=> packet_done_out ##1 !packet_done_out)
        else $error("commit not reported as one pulse");
    AST_SELECT_ROUTES: assert property (
        wr_ev |=> count_reg[$past(sel_s)] != '0)
        else $error("write did not reach the selected FIFO");

    // Refused strobes leave the FIFO as it was; a taken write advances its write pointer
    AST_EMPTY_REFUSES: assert property (
        (link_edge && cs_s && rd_s && count_reg[sel_s] == '0)
        |=> rd_ptr_reg[$past(sel_s)] == $past(rd_ptr_reg[sel_s]))
        else $error("read of an empty FIFO moved its pointer");
    AST_FULL_REFUSES: assert property (
        (link_edge && cs_s && wr_s && !rd_s
            && count_reg[sel_s] == cnt_type'(DEPTH))
        |=> count_reg[$past(sel_s)] == cnt_type'(DEPTH))
        else $error("write into a full FIFO changed its fill");
    AST_READ_IGNORES_NO_CS: assert property (
        (link_edge && rd_s && !cs_s)
        |=> rd_ptr_reg[$past(sel_s)] == $past(rd_ptr_reg[sel_s]))
        else $error("read taken without chip select");
    AST_WRITE_ADVANCES: assert property (
        wr_ev |=> wr_ptr_reg[$past(sel_s)]
            == ptr_type'($past(wr_ptr_reg[sel_s]) + 1'b1))
        else $error("write edge did not advance the pointer");

    // Flag levels track the fill of the selected FIFO
    AST_FLAGS_MATCH_FILL: assert property (
        1'b1 |=> (fifo_empty_out == (count_reg[$past(sel_s)] == '0))
            && (fifo_full_out
                == (count_reg[$past(sel_s)] == cnt_type'(DEPTH))))
        else $error("flags do not match the fill count");

    // Commit bookkeeping
    AST_AUTO_COMMIT: assert property (
        auto_ev |=> packet_done_out
            && packet_words_out == $past(auto_commit_length_in))
        else $error("auto commit reported the wrong length");
    AST_COMMIT_CLEARS: assert property (
        pkt_ev |=> pend_reg[$past(sel_s)] == '0)
        else $error("commit left words in the open packet");
    AST_PACKET_SELECT: assert property (
        (pkt_ev || auto_ev) |=> packet_select_out == $past(sel_s))
        else $error("packet reported for the wrong FIFO");
    AST_DONE_QUIET: assert property (
        (!pkt_ev && !auto_ev) |=> !packet_done_out)
        else $error("packet reported without a commit");
endmodule : slave_fifo_host_port
`default_nettype wire

/* File: logic/slave_port_map.svh */
/*
 Constants of the slave FIFO host port: widths, reset values, counts.
 Assumes inclusion by the package and by the port module only.
*/
`ifndef SLAVE_PORT_MAP_SVH
`define SLAVE_PORT_MAP_SVH

// Bus and FIFO geometry
`define SPM_DATA_W 16
`define SPM_DEPTH_LOG2 4
`define SPM_FIFO_CNT 4
`define SPM_SEL_W 2

// Synchroniser width: clock, five strobes, select and data pins
`define SPM_SYNC_W 24

// Reset values
`define SPM_PTR_RST 4'h0
`define SPM_DATA_RST 16'h0000

`endif

/* File: logic/slave_port_pkg.sv */
/*
 Types shared by the slave FIFO host port.
 Assumes the map header sits beside it.
*/
`include "slave_port_map.svh"

package slave_port_pkg;
    typedef logic [`SPM_SEL_W-1:0] fifo_sel_type;
    typedef logic [`SPM_DATA_W-1:0] word_type;
endpackage : slave_port_pkg
